/* File: rtl/tcad_pkg.sv */
// Purpose: shared constants for the timer command area decoder
// Assumes: 32-bit command/definition entries in a word-addressed area
// Notes:   offsets are byte addresses into the register window
package tcad_pkg;
   // entry field positions
   localparam int CMP_LSB      = 0;
   localparam int CMP_W        = 16;
   localparam int NXT_BIT      = 16;
   localparam int IC_BIT       = 17;
   localparam int PIN_LSB      = 18;
   localparam int PIN_W        = 3;
   localparam int CA_BIT       = 21;
   localparam int STEP_BIT     = 22;
   localparam int RA_BIT       = 25;
   localparam int IR_BIT       = 26;
   localparam int EN_BIT       = 27;
   localparam int VT_INT_BIT   = 17;
   localparam int VT_RUN_BIT   = 18;
   localparam int RANGE_BIT    = 19;
   localparam int EXT_LSB      = 20;
   localparam int RAD_LSB      = 23;
   localparam int RAD_W        = 9;
   localparam int VAL_LSB      = 1;
   localparam int VAL_W        = 15;
   localparam logic [2:0] PIN_NONE = 3'h7;
   // register map (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_BOUNDS = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_PINS   = 8'h0C;
   localparam logic [7:0] REG_AREA   = 8'h40;
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_PRE_LSB = 8;
   localparam int CTRL_PRE_W   = 4;
   localparam int SCAN_STEPS   = 4;
   localparam logic [1:0] WRAP_DELAY = 2'h2;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   typedef enum logic [1:0] {TCAD_CMD, TCAD_DEF1, TCAD_DEF2} tcad_slot_t;
endpackage

/* File: rtl/tcad_decoder.sv */
// Purpose: scans a command/definition area, runs virtual timers and compares
// Assumes: area held locally, written by the host over Avalon-MM
// Notes:   one entry slot per prescaled tick, one per four ticks in step operation
//
// How it works
// - a standard compare matches bits 15..0 against the nearest virtual timer above it, else the reference timer.
// - a command with bit 16 set makes the next entry a timer definition.
// - a standard compare takes exactly one slot of the scan.
// - with range bit 0 the maximum is radical at bits 12..4 and bits 22..20 at bits 3..1.
// - with range bit 1 bits 22..20 go to 15..13, radical at 12..4, bits 3..1 are ones.
// - in step operation each entry slot spans four resolution periods, comparisons still per resolution.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tcad_decoder #(
   parameter int AREA_WORDS = 16,
   parameter int NUM_PINS   = 7
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [NUM_PINS-1:0] match_pin_level,
   output logic             match_interrupt
);
   localparam int AW = $clog2(AREA_WORDS);
   if (AREA_WORDS < 2 || AREA_WORDS > 16 || NUM_PINS != 7)
      $error("tcad_decoder parameters out of range");

   logic [31:0] area_ff [AREA_WORDS];
   logic [31:0] nxt_area [AREA_WORDS];
   logic [3:0]  pre_ff, nxt_pre;
   logic [3:0]  pre_sel_ff, nxt_pre_sel;
   logic        run_ff, nxt_run;
   logic [AW-1:0] first_ff, nxt_first, last_ff, nxt_last;
   logic [AW-1:0] idx_ff, nxt_idx;
   tcad_pkg::tcad_slot_t slot_ff, nxt_slot;
   logic        has_vt_ff, nxt_has_vt;
   logic [15:0] vt_ff, nxt_vt;
   logic        vt_zero_ff, nxt_vt_zero;
   logic [1:0]  wrap_ff [AREA_WORDS];
   logic [1:0]  nxt_wrap [AREA_WORDS];
   logic [AREA_WORDS-1:0] lsb_ff, nxt_lsb;
   logic [15:0] ref_ff, nxt_ref;
   logic        coarse_scan_ff, nxt_coarse;
   logic [1:0]  phase_ff, nxt_phase;
   logic [NUM_PINS-1:0] pin_ff, nxt_pin;
   logic        irq_ff, nxt_irq;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        ack_ff, nxt_ack;

   wire logic tick = clk_en && run_ff && (pre_ff == pre_sel_ff);
   wire logic [31:0] ent = area_ff[idx_ff];
   wire logic [2:0] ent_pin = ent[tcad_pkg::PIN_LSB +: tcad_pkg::PIN_W];
   wire logic [AW-1:0] idx_nx = (idx_ff == last_ff) ? first_ff
                                                    : AW'(idx_ff + 1'b1);

   function automatic logic [15:0] vt_max(input logic [31:0] e);
      logic [2:0] ext;
      ext = e[tcad_pkg::EXT_LSB +: 3];
      if (e[tcad_pkg::RANGE_BIT])
         vt_max = {ext, e[tcad_pkg::RAD_LSB +: tcad_pkg::RAD_W],
                   3'h7, 1'b0};
      else
         vt_max = {3'h0, e[tcad_pkg::RAD_LSB +: tcad_pkg::RAD_W],
                   ext, 1'b0};
   endfunction

   // scan, timers and compares
   always_comb
   begin
      logic [15:0] cur;
      logic [15:0] tmax;
      logic [2:0]  psel;
      logic        hit, zero_hit, adv;
      cur = 16'h0000;
      tmax = 16'h0000;
      psel = 3'h0;
      hit = 1'b0;
      zero_hit = 1'b0;
      adv = 1'b0;
      nxt_area = area_ff;
      nxt_wrap = wrap_ff;
      nxt_lsb = lsb_ff;
      nxt_idx = idx_ff;
      nxt_slot = slot_ff;
      nxt_has_vt = has_vt_ff;
      nxt_vt = vt_ff;
      nxt_vt_zero = vt_zero_ff;
      nxt_ref = ref_ff;
      nxt_coarse = coarse_scan_ff;
      nxt_phase = phase_ff;
      nxt_pin = pin_ff;
      nxt_irq = 1'b0;
      if (tick)
      begin
         // step mode: each entry waits out all four phases
         adv = !coarse_scan_ff || (phase_ff == 2'(tcad_pkg::SCAN_STEPS-1));
         nxt_phase = coarse_scan_ff ? 2'(phase_ff + 1'b1) : 2'h0;
         if (idx_ff == first_ff && slot_ff == tcad_pkg::TCAD_CMD && adv)
            nxt_ref = 16'(ref_ff + 1'b1);
         case (slot_ff)
            tcad_pkg::TCAD_CMD:
            begin
               cur = has_vt_ff ? vt_ff : ref_ff;
               hit = (ent[tcad_pkg::CMP_LSB +: tcad_pkg::CMP_W] == cur);
               zero_hit = has_vt_ff ? vt_zero_ff : (ref_ff == 16'h0000);
               psel = ent[tcad_pkg::PIN_LSB +: tcad_pkg::PIN_W];
               if (ent[tcad_pkg::STEP_BIT])
                  nxt_coarse = 1'b1;
               if (ent[tcad_pkg::EN_BIT] && psel != tcad_pkg::PIN_NONE)
               begin
                  if (hit)
                     nxt_pin[psel] = ent[tcad_pkg::CA_BIT];
                  else if (zero_hit && ent[tcad_pkg::RA_BIT])
                     nxt_pin[psel] = !ent[tcad_pkg::CA_BIT];
               end
               nxt_irq = (hit && ent[tcad_pkg::IC_BIT]) ||
                         (zero_hit && ent[tcad_pkg::IR_BIT]);
               if (adv)
               begin
                  nxt_slot = ent[tcad_pkg::NXT_BIT] ? tcad_pkg::TCAD_DEF1
                                                    : tcad_pkg::TCAD_CMD;
                  nxt_idx = idx_nx;
                  if (idx_ff == last_ff)
                     nxt_has_vt = 1'b0;
               end
            end
            tcad_pkg::TCAD_DEF1:
               if (adv)
                  nxt_slot = tcad_pkg::TCAD_DEF2;
            tcad_pkg::TCAD_DEF2:
            begin
               tmax = vt_max(ent);
               cur = {ent[tcad_pkg::VAL_LSB +: tcad_pkg::VAL_W], 1'b0};
               cur[0] = lsb_ff[idx_ff];
               if (adv)
               begin
                  nxt_vt_zero = 1'b0;
                  if (ent[tcad_pkg::VT_RUN_BIT])
                  begin
                     // hold one visit at max, clear on the second
                     if (wrap_ff[idx_ff] == 2'(tcad_pkg::WRAP_DELAY - 2'h1))
                     begin
                        cur = 16'h0000;
                        nxt_wrap[idx_ff] = 2'h0;
                        nxt_vt_zero = 1'b1;
                        nxt_irq = ent[tcad_pkg::VT_INT_BIT];
                     end
                     else if (wrap_ff[idx_ff] != 2'h0 || cur >= tmax)
                        nxt_wrap[idx_ff] = 2'(wrap_ff[idx_ff] + 1'b1);
                     else
                        cur = 16'(cur + 16'h0001);
                     nxt_area[idx_ff][tcad_pkg::VAL_LSB +: tcad_pkg::VAL_W]
                        = cur[15:1];
                     nxt_lsb[idx_ff] = cur[0];
                  end
                  nxt_vt = cur;
                  nxt_has_vt = (idx_ff != last_ff);
                  nxt_slot = tcad_pkg::TCAD_CMD;
                  nxt_idx = idx_nx;
               end
            end
            default:
               nxt_slot = tcad_pkg::TCAD_CMD;
         endcase
      end
      if (clk_en && avs_write && !ack_ff &&
          avs_address >= tcad_pkg::REG_AREA)
      begin
         nxt_lsb[AW'(avs_address[7:2])] = 1'b0;
         for (int b = 0; b < 4; b++)
            if (avs_byteenable[b])
               nxt_area[AW'(avs_address[7:2])][8*b +: 8]
                  = avs_writedata[8*b +: 8];
      end
   end

   // register bus: every access answers one cycle after it is seen
   always_comb
   begin
      nxt_ack = clk_en && (avs_read || avs_write) && !ack_ff;
      nxt_rdata = rdata_ff;
      nxt_pre = (!clk_en || !run_ff || tick) ? 4'h0 : 4'(pre_ff + 1'b1);
      nxt_pre_sel = pre_sel_ff;
      nxt_run = run_ff;
      nxt_first = first_ff;
      nxt_last = last_ff;
      if (nxt_ack && avs_read)
      begin
         case (avs_address)
            tcad_pkg::REG_CTRL:
               nxt_rdata = {20'h0, pre_sel_ff, 7'h0, run_ff};
            tcad_pkg::REG_BOUNDS:
               nxt_rdata = {16'h0, 8'(last_ff), 8'(first_ff)};
            tcad_pkg::REG_STATUS:
               nxt_rdata = {12'h0, 2'(slot_ff), 2'(phase_ff), ref_ff};
            tcad_pkg::REG_PINS:
               nxt_rdata = {25'h0, pin_ff};
            default:
               nxt_rdata = (avs_address >= tcad_pkg::REG_AREA &&
                            avs_address[7:2] < 6'(16 + AREA_WORDS))
                  ? area_ff[AW'(avs_address[7:2])] : tcad_pkg::RD_UNMAPPED;
         endcase
      end
      if (nxt_ack && avs_write)
      begin
         if (avs_address == tcad_pkg::REG_CTRL)
         begin
            nxt_run = avs_writedata[tcad_pkg::CTRL_EN_BIT];
            nxt_pre_sel = avs_writedata[tcad_pkg::CTRL_PRE_LSB +:
                                        tcad_pkg::CTRL_PRE_W];
         end
         if (avs_address == tcad_pkg::REG_BOUNDS)
         begin
            nxt_first = AW'(avs_writedata[7:0]);
            nxt_last = AW'(avs_writedata[15:8]);
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < AREA_WORDS; i++)
         begin
            area_ff[i] <= 32'h0000_0000;
            wrap_ff[i] <= 2'h0;
         end
         lsb_ff <= '0;
         pre_ff <= 4'h0;
         pre_sel_ff <= 4'h0;
         run_ff <= 1'b0;
         first_ff <= '0;
         last_ff <= '0;
         idx_ff <= '0;
         slot_ff <= tcad_pkg::TCAD_CMD;
         has_vt_ff <= 1'b0;
         vt_ff <= 16'h0000;
         vt_zero_ff <= 1'b0;
         ref_ff <= 16'h0000;
         coarse_scan_ff <= 1'b0;
         phase_ff <= 2'h0;
         pin_ff <= '0;
         irq_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         ack_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         area_ff <= nxt_area;
         wrap_ff <= nxt_wrap;
         lsb_ff <= nxt_lsb;
         pre_ff <= nxt_pre;
         pre_sel_ff <= nxt_pre_sel;
         run_ff <= nxt_run;
         first_ff <= nxt_first;
         last_ff <= nxt_last;
         idx_ff <= nxt_idx;
         slot_ff <= nxt_slot;
         has_vt_ff <= nxt_has_vt;
         vt_ff <= nxt_vt;
         vt_zero_ff <= nxt_vt_zero;
         ref_ff <= nxt_ref;
         coarse_scan_ff <= nxt_coarse;
         phase_ff <= nxt_phase;
         pin_ff <= nxt_pin;
         irq_ff <= nxt_irq;
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
   assign match_pin_level = pin_ff;
   assign match_interrupt = irq_ff;

   // checks
   property p_cmd_one_slot;
      @(posedge mclk) disable iff (!reset_n)
      (tick && slot_ff == tcad_pkg::TCAD_CMD && !coarse_scan_ff
       && !ent[tcad_pkg::NXT_BIT] && idx_ff != last_ff)
      |=> (idx_ff == $past(idx_ff) + 1'b1);
   endproperty
   a_cmd_one_slot: assert property (p_cmd_one_slot)
      else $error("compare did not take one slot");

   property p_def_follows;
      @(posedge mclk) disable iff (!reset_n)
      (tick && slot_ff == tcad_pkg::TCAD_CMD && !coarse_scan_ff
       && ent[tcad_pkg::NXT_BIT]) |=> (slot_ff == tcad_pkg::TCAD_DEF1);
   endproperty
   a_def_follows: assert property (p_def_follows)
      else $error("definition not decoded after flag");

   property p_coarse_hold;
      @(posedge mclk) disable iff (!reset_n)
      (clk_en && coarse_scan_ff && tick &&
       phase_ff != 2'(tcad_pkg::SCAN_STEPS - 1))
      |=> (idx_ff == $past(idx_ff));
   endproperty
   a_coarse_hold: assert property (p_coarse_hold)
      else $error("step scan advanced early");

   property p_irq_pulse;
      @(posedge mclk) disable iff (!reset_n)
      match_interrupt && clk_en |=> !match_interrupt || $past(tick);
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("interrupt without a slot");

   property p_wrap_clear;
      @(posedge mclk) disable iff (!reset_n)
      (tick && slot_ff == tcad_pkg::TCAD_DEF2 && !coarse_scan_ff &&
       ent[tcad_pkg::VT_RUN_BIT] && wrap_ff[idx_ff] != 2'h0)
      |=> (vt_ff == 16'h0000 && vt_zero_ff);
   endproperty
   a_wrap_clear: assert property (p_wrap_clear)
      else $error("virtual timer did not clear");

   property p_ref_compare;
      @(posedge mclk) disable iff (!reset_n)
      (tick && slot_ff == tcad_pkg::TCAD_CMD && !has_vt_ff &&
       ent[tcad_pkg::EN_BIT] && ent_pin != tcad_pkg::PIN_NONE &&
       ent[tcad_pkg::CMP_LSB +: tcad_pkg::CMP_W] == ref_ff)
      |=> (match_pin_level[$past(ent_pin)] == $past(ent[tcad_pkg::CA_BIT]));
   endproperty
   a_ref_compare: assert property (p_ref_compare)
      else $error("reference compare did not act on pin");
endmodule
`default_nettype wire

/* File: sim/tcad_host_model.sv */
// Purpose: host side model that fills and updates the command area
// Assumes: Avalon-MM slave with waitrequest, one request at a time
// Notes:   released write data is inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module tcad_host_model (
   input  wire logic        mclk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic [7:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata
);
   initial
   begin
      avs_address   = 8'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0000_0000;
   end

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      @(posedge mclk iff avs_waitrequest === 1'b0);
      avs_write     <= 1'b0;
      avs_writedata <= ~d;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge mclk iff avs_waitrequest === 1'b0);
      d = avs_readdata;
      avs_read    <= 1'b0;
   endtask

   // a host write wins over a timer update, but a running timer may move the value between read and write, so stop it around the load
   task automatic load_timer(input logic [7:0] a, input logic [14:0] v);
      logic [31:0] w;
      bus_read(a, w);
      w[tcad_pkg::VT_RUN_BIT] = 1'b0;
      bus_write(a, w);
      w[tcad_pkg::VAL_LSB +: tcad_pkg::VAL_W] = v;
      bus_write(a, w);
      w[tcad_pkg::VT_RUN_BIT] = 1'b1;
      bus_write(a, w);
   endtask
endmodule
`default_nettype wire

/* File: sim/timer_command_area_decoder_test.sv */
// Purpose: self-checking bench for the command area decoder
// Assumes: prescale 0, so one entry slot per clock, one per four clocks in step mode
// Notes:   scan rates are checked with a small tolerance for bus latency
`timescale 1ns/1ps
`default_nettype none
module timer_command_area_decoder_test;
   logic        mclk;
   logic        reset_n;
   logic        clk_en;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [6:0]  match_pin_level;
   logic        match_interrupt;
   int          error_cnt;
   int          n_checks;
   int          n;
   logic [31:0] rd;
   logic [31:0] t0;
   logic [15:0] d;
   logic [31:0] defs [3] = '{32'h000C_0000, 32'h0064_0000, 32'h0074_0000};
   logic [1:0]  pexp [3] = '{2'h3, 2'h2, 2'h3};
   int          rate [3] = '{201, 50, 101};

   tcad_decoder #(.AREA_WORDS(16), .NUM_PINS(7)) tcad_decoder_i (
      .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .match_pin_level(match_pin_level),
      .match_interrupt(match_interrupt));

   tcad_host_model tcad_host_model_i (
      .mclk(mclk), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic do_reset;
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
   endtask

   task automatic area(input int i, input logic [31:0] w);
      tcad_host_model_i.bus_write(tcad_pkg::REG_AREA + 8'(4 * i), w);
   endtask

   // bounds first, then run with prescale 0
   task automatic start(input logic [7:0] last);
      tcad_host_model_i.bus_write(tcad_pkg::REG_BOUNDS, {16'h0, last, 8'h00});
      tcad_host_model_i.bus_write(tcad_pkg::REG_CTRL, 32'h0000_0001);
   endtask

   initial
   begin
      reset_n   = 1'b0;
      clk_en    = 1'b1;
      error_cnt = 0;
      n_checks  = 0;
      do_reset;
      tcad_host_model_i.bus_read(8'h30, rd);
      check("unmapped read", rd, tcad_pkg::RD_UNMAPPED);
      $display("bus test done");
      // pin1 follows the reference timer, pin0 the virtual timer
      for (int k = 0; k < 3; k++)
      begin
         do_reset;
         area(0, 32'h0824_0010);
         area(1, 32'h0001_0000);
         area(2, defs[k]);
         area(3, 32'h0820_000E);
         tcad_host_model_i.load_timer(tcad_pkg::REG_AREA + 8'h08, 15'h0000);
         start(8'h03);
         repeat (1500) @(posedge mclk);
         check("pin port", {25'h0, match_pin_level}, {30'h0, pexp[k]});
         tcad_host_model_i.bus_read(tcad_pkg::REG_PINS, rd);
         check("pin register", rd, {30'h0, pexp[k]});
         $display("range test %0d done", k);
      end
      // three scan rates: plain, step mode, and a stretch with clk_en low
      for (int s = 0; s < 3; s++)
      begin
         do_reset;
         for (int i = 0; i < 3; i++)
            area(i, (s == 1) ? 32'h0040_0100 : 32'h0000_0100);
         start(8'h02);
         repeat (40) @(posedge mclk);
         tcad_host_model_i.bus_read(tcad_pkg::REG_STATUS, t0);
         repeat (300) @(posedge mclk);
         clk_en <= (s != 2);
         repeat (300) @(posedge mclk);
         clk_en <= 1'b1;
         tcad_host_model_i.bus_read(tcad_pkg::REG_STATUS, rd);
         d = rd[15:0] - t0[15:0];
         check("scan rate", {31'h0, (int'(d) >= rate[s] - 2 && int'(d) <= rate[s] + 2)}, 32'h1);
         $display("scan test %0d done", s);
      end
      // wrap period: (max 0x0E + 2) scans of three slots each
      do_reset;
      area(0, 32'h0001_0000);
      area(1, 32'h000E_0000);
      start(8'h01);
      @(posedge mclk iff match_interrupt === 1'b1);
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (match_interrupt !== 1'b1 && n < 200);
      check("wrap period", n, 32'h30);
      $display("wrap test done");
      print_verdict;
   end

   initial
   begin
      #(4 * 40000);
      error_cnt++;
      print_verdict;
   end
endmodule
`default_nettype wire
